// >>> hw/cldc_map.vh
/*
 * Constants for the charge limit and DAC control block: APB offsets,
 * field positions, reset values, limit tables and timing counts.
 * Assumes inclusion by bare name from design files under hw/ and the bench under dv/.
 */
`ifndef CLDC_MAP_VH
`define CLDC_MAP_VH

`define CLDC_OFF_CURRENT 12'h000
`define CLDC_OFF_VOLTAGE 12'h004
`define CLDC_OFF_CONFIG 12'h008
`define CLDC_OFF_STATUS 12'h00C
`define CLDC_OFF_VDAC 12'h010
`define CLDC_OFF_IDAC 12'h014

`define CLDC_CFG_LOW_CURRENT_MODE_DIS 0
`define CLDC_CFG_WAKE 1
`define CLDC_CFG_RESET 2'h0

`define CLDC_ST_AC 0
`define CLDC_ST_POWER_FAIL_FLAG 1
`define CLDC_ST_V_OR 2
`define CLDC_ST_LOW_CURRENT_MODE 3
`define CLDC_ST_WAKE 4
`define CLDC_ST_GOT_I 5
`define CLDC_ST_GOT_V 6

`define CLDC_I_MAX0 16'd1023
`define CLDC_I_MAX1 16'd2046
`define CLDC_I_MAX2 16'd3068
`define CLDC_I_MAX3 16'd4092
`define CLDC_I_STEP0 16'd1
`define CLDC_I_STEP1 16'd2
`define CLDC_I_STEP2 16'd4
`define CLDC_I_STEP3 16'd4
`define CLDC_I_WAKE 16'd80

`define CLDC_V_MIN 16'd2900
`define CLDC_V_STEP 16'd16
`define CLDC_V_REF 16'd1184
`define CLDC_V_MAX0 16'd8800
`define CLDC_V_MAX1 16'd13104
`define CLDC_V_MAX2 16'd17408
`define CLDC_V_MAX3 16'd21712
`define CLDC_V_MAX4 16'd28000

`define CLDC_CLK_HZ 10000000
`define CLDC_LOW_CURRENT_MODE_BIT_US 45000
`define CLDC_LOW_CURRENT_MODE_BIT_CYC (`CLDC_CLK_HZ / 1000000 * `CLDC_LOW_CURRENT_MODE_BIT_US)
`define CLDC_PWM_PHASES 8

`endif

// >>> hw/cldc_mod.v
/*
 * First order delta-sigma modulator for the current DAC.
 * Assumes the caller gives the step enable and a stable full scale.
 */
`timescale 1ns/1ps
module cldc_mod (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire ce,
    input wire step,
    input wire [15:0] level,
    input wire [15:0] full,
    output reg bit_out
);
reg [16:0] acc;
wire [16:0] sum = acc + {1'b0, level};

always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        acc <= 17'h0;
        bit_out <= 1'b0;
    end else if (ce && step) begin
        // density of ones equals level/full
        if (sum >= {1'b0, full}) begin
            acc <= sum - {1'b0, full};
            bit_out <= 1'b1;
        end else begin
            acc <= sum;
            bit_out <= 1'b0;
        end
    end
end
endmodule

// >>> hw/cldc_top.v
/*
 * Charge limit and DAC control: strap decode, voltage and current DAC
 * words, delta-sigma current drive, input enable and AC presence.
 * Registers: current word, voltage word, config, status, voltage DAC
 * readback and modulator level readback (before the x8 low-current
 * scaling), one word each on APB.
 * Assumes comparator results arrive as levels of unknown timing and an
 * APB master on REF_CLK.
 * Assumes the strap resistors stay put while charging; a strap code
 * that is not a clean thermometer is ignored and the last range kept.
 * Assumes the analog side scales the current bitstream by the sense
 * resistor and gates its output stage with CURRENT_DAC_OUT.
 */
`timescale 1ns/1ps
`include "cldc_map.vh"
module cldc_top (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [2:0] CURRENT_LIMIT_PIN,
    input wire [3:0] VOLTAGE_LIMIT_PIN,
    input wire INPUT_ABOVE_130MV,
    input wire INPUT_BELOW_NEG25MV,
    input wire AC_ABOVE_THRESHOLD,
    input wire AC_BELOW_HYSTERESIS,
    input wire BATTERY_INSERTED,
    output reg CHARGE_ENABLE_PIN,
    output reg AC_DETECT_OUTPUT,
    output reg INPUT_SWITCH_FAST_OFF,
    output reg [15:0] VOLTAGE_DAC,
    output reg CURRENT_DAC_OUT
);
// 45ms in clock cycles at 10MHz
localparam [31:0] LOW_CURRENT_MODE_CYC = `CLDC_LOW_CURRENT_MODE_BIT_CYC;

// thermometer code of strap comparators to range index
function [2:0] thermo;
    input [3:0] t;
    begin
        thermo = {2'b00, t[0]} + {2'b00, t[1]} + {2'b00, t[2]}
            + {2'b00, t[3]};
    end
endfunction

function [15:0] sat;
    input [15:0] v;
    input [15:0] lim;
    begin
        sat = (v > lim) ? lim : v;
    end
endfunction

// round a word down to its programming step
function [15:0] floor_step;
    input [15:0] v;
    input [15:0] s;
    begin
        floor_step = v - (v % s);
    end
endfunction

// register reads are 16-bit values in the low half of the bus
function [31:0] word32;
    input [15:0] v;
    begin
        word32 = {16'h0000, v};
    end
endfunction

// two flops per comparator; first stage read only by second
reg [11:0] sync_a;
reg [11:0] sync_b;
wire [11:0] cmp_in = {BATTERY_INSERTED, AC_BELOW_HYSTERESIS,
    AC_ABOVE_THRESHOLD, INPUT_BELOW_NEG25MV, INPUT_ABOVE_130MV,
    VOLTAGE_LIMIT_PIN, CURRENT_LIMIT_PIN};
always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        sync_a <= 12'h000;
        sync_b <= 12'h000;
    end else if (CE) begin
        sync_a <= cmp_in;
        sync_b <= sync_a;
    end
end
wire [2:0] current_limit_pin_t = sync_b[2:0];
wire [3:0] voltage_limit_pin_t = sync_b[6:3];
wire in_ok = sync_b[7];
wire in_rev = sync_b[8];
wire ac_hi = sync_b[9];
wire ac_lo = sync_b[10];
wire batt = sync_b[11];
reg batt_d;

// strap decode: zero means short, highest means open
// strap code must be a clean thermometer; a bubble from comparators
// caught mid-switch keeps the last good range
function thermo_ok;
    input [3:0] t;
    begin
        thermo_ok = ((t & (t + 4'h1)) == 4'h0);
    end
endfunction

reg [2:0] current_limit_pin_sel;
reg [2:0] voltage_limit_pin_sel;
// lowest ranges until a clean code is seen
always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        current_limit_pin_sel <= 3'h0;
        voltage_limit_pin_sel <= 3'h0;
    end else if (CE) begin
        if (thermo_ok({1'b0, current_limit_pin_t}))
            current_limit_pin_sel <= thermo({1'b0, current_limit_pin_t});
        if (thermo_ok(voltage_limit_pin_t))
            voltage_limit_pin_sel <= thermo(voltage_limit_pin_t);
    end
end
reg [15:0] i_max;
reg [15:0] i_step;
reg [15:0] v_max;
always @* begin
    case (current_limit_pin_sel[1:0])
        2'd0: begin
            i_max = `CLDC_I_MAX0;
            i_step = `CLDC_I_STEP0;
        end
        2'd1: begin
            i_max = `CLDC_I_MAX1;
            i_step = `CLDC_I_STEP1;
        end
        2'd2: begin
            i_max = `CLDC_I_MAX2;
            i_step = `CLDC_I_STEP2;
        end
        default: begin
            i_max = `CLDC_I_MAX3;
            i_step = `CLDC_I_STEP3;
        end
    endcase
    case (voltage_limit_pin_sel)
        3'd0: v_max = `CLDC_V_MAX0;
        3'd1: v_max = `CLDC_V_MAX1;
        3'd2: v_max = `CLDC_V_MAX2;
        3'd3: v_max = `CLDC_V_MAX3;
        default: v_max = `CLDC_V_MAX4;
    endcase
end

// software state
// CE low freezes all of it, the APB answer too
reg [15:0] cur_word;
reg [15:0] volt_word;
reg [1:0] cfg;
reg got_i;
reg got_v;
reg v_or;
reg wake;
reg low_current_mode;
reg pwr_ok;
reg ac_flag;

wire setup = PSEL && !PENABLE;
wire wr_acc = PSEL && PENABLE && PWRITE && PREADY;
wire addr_ok = (PADDR == `CLDC_OFF_CURRENT) ||
    (PADDR == `CLDC_OFF_VOLTAGE) || (PADDR == `CLDC_OFF_CONFIG) ||
    (PADDR == `CLDC_OFF_STATUS) || (PADDR == `CLDC_OFF_VDAC) ||
    (PADDR == `CLDC_OFF_IDAC);

// bit 1 reads power fail, the inverse of the enable condition
wire [31:0] status_word = {25'h0, got_v, got_i, wake, low_current_mode,
    v_or, ~pwr_ok, ac_flag};

// voltage DAC word: offset removed, clamped to strap ceiling
wire [15:0] v_q = floor_step(volt_word, `CLDC_V_STEP);
wire v_over = v_q > v_max;
wire [15:0] v_lim = sat(v_q, v_max);
wire [15:0] next_vdac = (v_q < `CLDC_V_REF) ? 16'h0000
    : v_lim - `CLDC_V_REF;

// current word: quantise to strap step, clamp to range
wire [15:0] i_q = floor_step(cur_word, i_step);
wire [15:0] i_cl = sat(i_q, i_max);
wire [15:0] mod_level = wake ? `CLDC_I_WAKE : i_cl;
wire [15:0] mod_full = wake ? `CLDC_I_MAX3 : i_max;
wire next_low_current_mode = !wake && !cfg[`CLDC_CFG_LOW_CURRENT_MODE_DIS] &&
    ({i_cl, 4'h0} < {4'h0, i_max});

always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        PRDATA <= 32'h00000000;
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        cur_word <= 16'h0000;
        volt_word <= 16'h0000;
        cfg <= `CLDC_CFG_RESET;
        got_i <= 1'b0;
        got_v <= 1'b0;
        v_or <= 1'b0;
        VOLTAGE_DAC <= 16'h0000;
        low_current_mode <= 1'b0;
    end else if (CE) begin
        // no wait state: ready in the first access cycle
        PREADY <= setup;
        PSLVERR <= setup && !addr_ok;
        // read data taken at setup so it stands through the access cycle
        if (setup) begin
            case (PADDR)
                `CLDC_OFF_CURRENT: PRDATA <= word32(cur_word);
                `CLDC_OFF_VOLTAGE: PRDATA <= word32(volt_word);
                `CLDC_OFF_CONFIG: PRDATA <= {30'h0, cfg};
                `CLDC_OFF_STATUS: PRDATA <= status_word;
                `CLDC_OFF_VDAC: PRDATA <= word32(VOLTAGE_DAC);
                `CLDC_OFF_IDAC: PRDATA <= word32(mod_level);
                default: PRDATA <= 32'h00000000;
            endcase
        end
        // new battery clears got_i and got_v but keeps the words; a write in the same cycle wins
        if (batt && !batt_d) begin
            got_i <= 1'b0;
            got_v <= 1'b0;
        end
        if (wr_acc) begin
            case (PADDR)
                `CLDC_OFF_CURRENT: begin
                    cur_word <= PWDATA[15:0];
                    got_i <= 1'b1;
                end
                `CLDC_OFF_VOLTAGE: begin
                    volt_word <= PWDATA[15:0];
                    got_v <= 1'b1;
                end
                `CLDC_OFF_CONFIG: cfg <= PWDATA[1:0];
                default: ;
            endcase
        end
        v_or <= v_over;
        VOLTAGE_DAC <= next_vdac;
        low_current_mode <= next_low_current_mode;
    end
end

// wake-up charging, input enable and AC presence
always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        batt_d <= 1'b0;
        wake <= 1'b0;
        pwr_ok <= 1'b0;
        ac_flag <= 1'b0;
        CHARGE_ENABLE_PIN <= 1'b0;
        AC_DETECT_OUTPUT <= 1'b0;
        INPUT_SWITCH_FAST_OFF <= 1'b0;
    end else if (CE) begin
        batt_d <= batt;
        // held while inserted battery lacks either word, or while the config wake bit is set
        wake <= (batt && !(got_i && got_v)) ||
            cfg[`CLDC_CFG_WAKE];
        if (in_rev)
            pwr_ok <= 1'b0;
        else if (in_ok)
            pwr_ok <= 1'b1;
        INPUT_SWITCH_FAST_OFF <= in_rev;
        CHARGE_ENABLE_PIN <= !in_rev && (pwr_ok || in_ok);
        if (ac_hi)
            ac_flag <= 1'b1;
        else if (ac_lo)
            ac_flag <= 1'b0;
        AC_DETECT_OUTPUT <= ac_hi || (ac_flag && !ac_lo);
    end
end

// modulator step: every cycle, or slow in low-current mode
// a slow bit gives the charger time to settle at the gated peak
reg [31:0] slow_cnt;
reg [2:0] pwm_ph;
wire slow_tick = (slow_cnt == LOW_CURRENT_MODE_CYC - 32'd1);
always @(posedge REF_CLK) begin
    if (SYS_RST) begin
        slow_cnt <= 32'h00000000;
        pwm_ph <= 3'h0;
    end else if (CE) begin
        pwm_ph <= pwm_ph + 3'h1;
        if (!low_current_mode || slow_tick)
            slow_cnt <= 32'h00000000;
        else
            slow_cnt <= slow_cnt + 32'h00000001;
    end
end

wire ds_bit;
// low-current level is scaled by 8 so the 1/8 gate restores the average
wire [15:0] ds_level = low_current_mode ? {i_cl[12:0], 3'h0} : mod_level;
cldc_mod u_mod (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .ce(CE),
    .step(!low_current_mode || slow_tick),
    .level(ds_level),
    .full(mod_full),
    .bit_out(ds_bit)
);

// low-current: bitstream gates a 1/8 duty pulse, so average matches
always @(posedge REF_CLK) begin
    if (SYS_RST)
        CURRENT_DAC_OUT <= 1'b0;
    else if (CE)
        CURRENT_DAC_OUT <= low_current_mode ? (ds_bit && pwm_ph == 3'h0)
            : ds_bit;
end
endmodule

// >>> dv/cldc_monitor.sv
/*
 * Port checker for cldc_top: enable, fast-off, AC flag, voltage ceiling.
 * Assumes the bind below and one clock with sync reset.
 */
`timescale 1ns/1ps
module cldc_monitor (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire CE,
    input wire PREADY,
    input wire PSLVERR,
    input wire [3:0] VOLTAGE_LIMIT_PIN,
    input wire INPUT_ABOVE_130MV,
    input wire INPUT_BELOW_NEG25MV,
    input wire AC_ABOVE_THRESHOLD,
    input wire AC_BELOW_HYSTERESIS,
    input wire CHARGE_ENABLE_PIN,
    input wire AC_DETECT_OUTPUT,
    input wire INPUT_SWITCH_FAST_OFF,
    input wire [15:0] VOLTAGE_DAC
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // cycles since the 130mV margin was last seen, saturating
    reg [3:0] since_up;
    always @(posedge REF_CLK) begin
        if (SYS_RST)
            since_up <= 4'hF;
        else if (INPUT_ABOVE_130MV)
            since_up <= 4'h0;
        else if (since_up != 4'hF)
            since_up <= since_up + 4'h1;
    end
    fast_off_a: assert property (
        (CE && INPUT_BELOW_NEG25MV)[*5] |-> INPUT_SWITCH_FAST_OFF)
        else $error("fast off missing");
    enable_off_a: assert property (
        (CE && INPUT_BELOW_NEG25MV)[*5] |-> !CHARGE_ENABLE_PIN)
        else $error("enable kept on reverse input");
    enable_rise_a: assert property (
        $rose(CHARGE_ENABLE_PIN) |-> since_up < 4'h6)
        else $error("enable without margin");
    ac_set_a: assert property (
        (CE && AC_ABOVE_THRESHOLD && !AC_BELOW_HYSTERESIS)[*5]
        |-> AC_DETECT_OUTPUT)
        else $error("ac output not set");
    ac_clear_a: assert property (
        (CE && AC_BELOW_HYSTERESIS && !AC_ABOVE_THRESHOLD)[*5]
        |-> !AC_DETECT_OUTPUT)
        else $error("ac output not cleared");
    ac_sync_a: assert property (
        $rose(AC_DETECT_OUTPUT) |-> $past(AC_ABOVE_THRESHOLD, 2)
        || $past(AC_ABOVE_THRESHOLD, 3) || $past(AC_ABOVE_THRESHOLD, 4))
        else $error("ac output not synchronised");
    vdac_top_a: assert property (
        VOLTAGE_DAC <= 16'h68C0)
        else $error("voltage above top ceiling");
    vdac_short_a: assert property (
        (VOLTAGE_LIMIT_PIN == 4'h0)[*6] |-> VOLTAGE_DAC <= 16'h1DC0)
        else $error("voltage above short strap ceiling");
    cover property ($rose(CHARGE_ENABLE_PIN));
    cover property ($rose(AC_DETECT_OUTPUT));
    cover property (PREADY && PSLVERR);
endmodule

bind cldc_top cldc_monitor chk (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .CE(CE),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .VOLTAGE_LIMIT_PIN(VOLTAGE_LIMIT_PIN),
    .INPUT_ABOVE_130MV(INPUT_ABOVE_130MV),
    .INPUT_BELOW_NEG25MV(INPUT_BELOW_NEG25MV),
    .AC_ABOVE_THRESHOLD(AC_ABOVE_THRESHOLD),
    .AC_BELOW_HYSTERESIS(AC_BELOW_HYSTERESIS),
    .CHARGE_ENABLE_PIN(CHARGE_ENABLE_PIN),
    .AC_DETECT_OUTPUT(AC_DETECT_OUTPUT),
    .INPUT_SWITCH_FAST_OFF(INPUT_SWITCH_FAST_OFF),
    .VOLTAGE_DAC(VOLTAGE_DAC)
);

// >>> dv/cldc_host.sv
/*
 * Host model sending charging words over APB.
 * Assumes xfer is called just after a rising edge.
 */
`timescale 1ns/1ps
module cldc_host (
    input wire clk,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [11:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // released lines flip so stale values never look valid
    task xfer(input [11:0] a, input w, input [31:0] d,
              output [31:0] q, output e);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            paddr <= ~a;
            pwdata <= ~d;
            @(posedge clk);
        end
    endtask
endmodule

// >>> dv/cldc_top_test.sv
/*
 * Self-checking bench for cldc_top: straps, DAC words, wake, enable, AC.
 * Assumes cldc_host as APB master and the map header.
 */
`timescale 1ns/1ps
`include "cldc_map.vh"
module cldc_top_test;
    reg ref_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [2:0] current_limit_pin = 3'h0;
    reg [3:0] voltage_limit_pin = 4'h0;
    reg above = 1'b0, below = 1'b0, ac_hi = 1'b0, ac_lo = 1'b0;
    reg batt = 1'b0, ce = 1'b1;
    wire psel, penable, pwrite, pready, pslverr, chg_en, ac_out, fast_off;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [15:0] vdac;
    wire dac_out;
    integer failures = 0, total_checks = 0, cycles = 0, i, n;
    reg [31:0] q;
    reg err;
    reg [15:0] vmax [0:4], imax [0:3], istep [0:3];
    reg [3:0] vpin [0:4];
    reg [2:0] ipin [0:3];
    always #50 ref_clk = ~ref_clk;
    cldc_host host (.clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    cldc_top uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CURRENT_LIMIT_PIN(current_limit_pin),
        .VOLTAGE_LIMIT_PIN(voltage_limit_pin), .INPUT_ABOVE_130MV(above),
        .INPUT_BELOW_NEG25MV(below), .AC_ABOVE_THRESHOLD(ac_hi),
        .AC_BELOW_HYSTERESIS(ac_lo), .BATTERY_INSERTED(batt),
        .CHARGE_ENABLE_PIN(chg_en), .AC_DETECT_OUTPUT(ac_out),
        .INPUT_SWITCH_FAST_OFF(fast_off), .VOLTAGE_DAC(vdac),
        .CURRENT_DAC_OUT(dac_out));
    task print_verdict;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input [11:0] a, input [15:0] d);
        host.xfer(a, 1'b1, {16'h0, d}, q, err);
    endtask
    task rd(input [11:0] a);
        host.xfer(a, 1'b0, 32'h0, q, err);
    endtask
    // status bit compare, after the flags settle
    task st(input integer b, input e);
        begin
            idle(2);
            rd(12'h00C);
            check({31'h0, q[b]}, {31'h0, e});
        end
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            print_verdict;
        end
    end
    initial begin
        vmax[0] = `CLDC_V_MAX0; vmax[1] = `CLDC_V_MAX1;
        vmax[2] = `CLDC_V_MAX2; vmax[3] = `CLDC_V_MAX3;
        vmax[4] = `CLDC_V_MAX4;
        vpin[0] = 4'h0; vpin[1] = 4'h1; vpin[2] = 4'h3;
        vpin[3] = 4'h7; vpin[4] = 4'hF;
        imax[0] = `CLDC_I_MAX0; imax[1] = `CLDC_I_MAX1;
        imax[2] = `CLDC_I_MAX2; imax[3] = `CLDC_I_MAX3;
        istep[0] = `CLDC_I_STEP0; istep[1] = `CLDC_I_STEP1;
        istep[2] = `CLDC_I_STEP2; istep[3] = `CLDC_I_STEP3;
        ipin[0] = 3'h0; ipin[1] = 3'h1; ipin[2] = 3'h3; ipin[3] = 3'h7;
        idle(3);
        sys_rst <= 1'b0;
        idle(1);
        check({31'h0, chg_en}, 32'h0);
        st(1, 1'b1);
        above <= 1'b1;
        idle(6);
        check({31'h0, chg_en}, 32'h1);
        st(1, 1'b0);
        ce <= 1'b0;
        below <= 1'b1;
        idle(6);
        check({31'h0, chg_en}, 32'h1);
        ce <= 1'b1;
        idle(6);
        check({30'h0, chg_en, fast_off}, 32'h1);
        below <= 1'b0;
        ac_hi <= 1'b1;
        idle(6);
        check({31'h0, ac_out}, 32'h1);
        st(0, 1'b1);
        ac_hi <= 1'b0;
        ac_lo <= 1'b1;
        idle(6);
        check({31'h0, ac_out}, 32'h0);
        st(0, 1'b0);
        for (i = 0; i < 5; i = i + 1) begin
            voltage_limit_pin <= vpin[i];
            idle(6);
            wr(12'h004, 16'h7530);
            idle(2);
            check({16'h0, vdac}, {16'h0, vmax[i] - `CLDC_V_REF});
            st(2, 1'b1);
        end
        wr(12'h004, 16'h03E8);
        idle(2);
        check({16'h0, vdac}, 32'h0);
        wr(12'h004, 16'h07D0);
        idle(2);
        check({16'h0, vdac}, {16'h0, 16'h07D0 - `CLDC_V_REF});
        wr(12'h004, 16'h1388);
        idle(2);
        check({16'h0, vdac}, {16'h0, 16'h1380 - `CLDC_V_REF});
        st(2, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            current_limit_pin <= ipin[i];
            idle(6);
            wr(12'h000, 16'h1388);
            rd(12'h014);
            check(q, {16'h0, imax[i]});
            wr(12'h000, imax[i] - 16'h0001);
            rd(12'h014);
            check(q, {16'h0, imax[i] - istep[i]});
            wr(12'h000, 16'h000A);
            st(3, 1'b1);
        end
        wr(12'h008, 16'h0001);
        st(3, 1'b0);
        wr(12'h008, 16'h0002);
        rd(12'h014);
        check(q, {16'h0, `CLDC_I_WAKE});
        st(4, 1'b1);
        wr(12'h008, 16'h0000);
        batt <= 1'b1;
        idle(6);
        st(4, 1'b1);
        wr(12'h000, 16'h01F4);
        wr(12'h004, 16'h2328);
        st(4, 1'b0);
        // over one full-scale span the ones count equals the word
        n = 0;
        repeat (`CLDC_I_MAX3) begin
            @(posedge ref_clk);
            n = n + dac_out;
        end
        check(n, 32'h1F4);
        // unmapped offset must be refused
        rd(12'h020);
        check({31'h0, err}, 32'h1);
        check(q, 32'h0);
        print_verdict;
    end
endmodule
